// [verilog/dps_consts.svh]
// Constants for the disk drive panel and status logic.
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH

// Clock rate in kilohertz and times in milliseconds.
`define DPS_CLK_KHZ 32'd250000
`define DPS_DEBOUNCE_MS 32'd10
`define DPS_BLINK_HALF_MS 32'd250
`define DPS_SPINUP_MS 32'd10000

// Register byte offsets on the bus.
`define DPS_OFF_STATUS 4'h0
`define DPS_OFF_MASK 4'h4
`define DPS_OFF_CTRL 4'h8
`define DPS_OFF_PANEL 4'hc

// Event bit positions in the status and mask registers.
`define DPS_EV_ONLINE 0
`define DPS_EV_DONE 1
`define DPS_EV_ERR 2
`define DPS_EV_UNSAFE 3
`define DPS_EV_W 4

// Control register layout and reset values.
`define DPS_CTRL_W 8
`define DPS_CTRL_LAMP_TEST 0
`define DPS_MASK_RST 4'h0
`define DPS_CTRL_RST 8'h00
`define DPS_PANEL_W 8

`endif

// [verilog/dps_pkg.sv]
// Types shared by the disk drive panel and status logic.
`default_nettype none
package dps_pkg;
    `include "dps_consts.svh"

    typedef enum logic [3:0] {
        SP_STOP = 4'b0001,
        SP_RAMP = 4'b0010,
        SP_RUN = 4'b0100,
        SP_FAULT = 4'b1000
    } dps_spin_t;

    typedef struct packed {
        logic spin_start;
        logic avail;
        logic wprot;
        logic sel_a;
        logic sel_b;
    } dps_sw_t;

    typedef struct packed {
        logic at_speed;
        logic temp_warn;
        logic airflow_low;
        logic act_a;
        logic act_b;
    } dps_sense_t;

    typedef struct packed {
        logic unsafe;
        logic online;
        logic wprot;
        logic act_a;
        logic act_b;
    } dps_lamp_t;

    typedef struct packed {
        logic motor_on;
        logic port_a_en;
        logic port_b_en;
        logic write_ok;
    } dps_drive_t;
endpackage : dps_pkg
`default_nettype wire

// [verilog/dps_panel.sv]
// Front-panel control and status logic of a fixed-media disk drive.
//
// Contract
// - Start position spins the sealed platter stack up; stop position stops it.
// - Availability switch up makes the drive available; down makes it unavailable.
// - Write-inhibit switch up lights its lamp and refuses host writes.
// - Port selector enables port A only, both ports, or port B only.
// - An unsafe condition such as a spin-up failure lights the unsafe lamp steadily.
// - Over-temperature warning or low airflow makes the unsafe lamp blink.
// - On-line lamp lit while available; off on switch down, stop or unsafe.
// - Activity lamps A and B light while the matching port accesses the drive.
// - Becoming available raises an interrupt, as do completion and errors.
`timescale 1ns/1ps
`default_nettype none
module dps_panel
    import dps_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYC = `DPS_DEBOUNCE_MS * `DPS_CLK_KHZ,
    parameter int unsigned BLINK_CYC = `DPS_BLINK_HALF_MS * `DPS_CLK_KHZ,
    parameter int unsigned SPINUP_CYC = `DPS_SPINUP_MS * `DPS_CLK_KHZ
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire dps_sw_t sw_i,
    input wire dps_sense_t sense_i,
    input wire logic op_done_i,
    input wire logic err_det_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    output dps_lamp_t lamp_o,
    output dps_drive_t drive_o
);

    typedef struct packed {
        dps_sw_t sw_s1;
        dps_sw_t sw_s2;
        dps_sw_t sw_s3;
        dps_sw_t sw_stab;
        logic [31:0] db_cnt;
        dps_sense_t se_s1;
        dps_sense_t se_s2;
        dps_spin_t spin;
        logic [31:0] spin_cnt;
        logic [31:0] blink_cnt;
        logic blink_ph;
        logic online;
        logic [`DPS_EV_W-1:0] status;
        logic [`DPS_EV_W-1:0] mask;
        logic [`DPS_CTRL_W-1:0] ctrl;
        logic ack;
        logic [31:0] dat;
        logic irq;
        dps_lamp_t lamps;
        dps_drive_t drive;
    } dps_state_t;

    dps_state_t st_q;
    dps_state_t st_d;

    logic en_a;
    logic en_b;
    logic warn;
    logic steady_now;
    logic steady_next;
    logic run_next;
    logic ramp_next;
    logic take;
    logic lamp_test;
    logic [`DPS_EV_W-1:0] ev;
    logic [`DPS_EV_W-1:0] clr;
    logic [`DPS_PANEL_W-1:0] panel;

    always_comb
    begin
        st_d = st_q;
        ev = '0;
        clr = '0;
        panel = '0;

        // Two-stage synchronisers for the switch and sense inputs.
        st_d.sw_s1 = sw_i;
        st_d.sw_s2 = st_q.sw_s1;
        st_d.sw_s3 = st_q.sw_s2;
        st_d.se_s1 = sense_i;
        st_d.se_s2 = st_q.se_s1;

        // The switch group settles only after a full quiet period; any bounce restarts it.
        if (st_q.sw_s2 != st_q.sw_s3)
        begin
            st_d.db_cnt = '0;
        end
        else if (st_q.sw_s2 != st_q.sw_stab)
        begin
            if (st_q.db_cnt >= DEBOUNCE_CYC - 32'd1)
            begin
                st_d.sw_stab = st_q.sw_s2;
                st_d.db_cnt = '0;
            end
            else
            begin
                st_d.db_cnt = st_q.db_cnt + 32'd1;
            end
        end
        else
        begin
            st_d.db_cnt = '0;
        end

        // Spindle sequencing with a spin-up watchdog.
        case (st_q.spin)
            SP_STOP:
            begin
                if (st_q.sw_stab.spin_start)
                begin
                    st_d.spin = SP_RAMP;
                    st_d.spin_cnt = '0;
                end
            end
            SP_RAMP:
            begin
                if (!st_q.sw_stab.spin_start)
                begin
                    st_d.spin = SP_STOP;
                end
                else if (st_q.se_s2.at_speed)
                begin
                    st_d.spin = SP_RUN;
                end
                else if (st_q.spin_cnt >= SPINUP_CYC - 32'd1)
                begin
                    st_d.spin = SP_FAULT;
                end
                else
                begin
                    st_d.spin_cnt = st_q.spin_cnt + 32'd1;
                end
            end
            SP_RUN:
            begin
                if (!st_q.sw_stab.spin_start)
                begin
                    st_d.spin = SP_STOP;
                end
                else if (!st_q.se_s2.at_speed)
                begin
                    st_d.spin = SP_FAULT;
                end
            end
            SP_FAULT:
            begin
                if (!st_q.sw_stab.spin_start)
                begin
                    st_d.spin = SP_STOP;
                end
            end
            default:
            begin
                st_d.spin = SP_STOP;
                st_d.spin_cnt = '0;
            end
        endcase

        // A fault holds until the operator turns the spindle switch to stop.
        steady_now = (st_q.spin == SP_FAULT);
        steady_next = (st_d.spin == SP_FAULT);
        run_next = (st_d.spin == SP_RUN);
        ramp_next = (st_d.spin == SP_RAMP);

        // Warning blink runs only while a warning is present.
        warn = st_q.se_s2.temp_warn | st_q.se_s2.airflow_low;
        if (warn)
        begin
            if (st_q.blink_cnt >= BLINK_CYC - 32'd1)
            begin
                st_d.blink_cnt = '0;
                st_d.blink_ph = ~st_q.blink_ph;
            end
            else
            begin
                st_d.blink_cnt = st_q.blink_cnt + 32'd1;
            end
        end
        else
        begin
            st_d.blink_cnt = '0;
            st_d.blink_ph = 1'b1;
        end

        // The drive is on line only when every panel condition allows it.
        st_d.online = st_q.sw_stab.avail
            & st_q.sw_stab.spin_start
            & run_next
            & ~steady_next;

        // Three-position selector with the middle position enabling both ports.
        en_a = st_q.sw_stab.sel_a | ~st_q.sw_stab.sel_b;
        en_b = st_q.sw_stab.sel_b | ~st_q.sw_stab.sel_a;

        st_d.drive.motor_on = ramp_next | run_next;
        st_d.drive.port_a_en = st_d.online & en_a;
        st_d.drive.port_b_en = st_d.online & en_b;
        st_d.drive.write_ok = ~st_q.sw_stab.wprot;

        // Panel lamps, all lit while the lamp test bit is set.
        lamp_test = st_q.ctrl[`DPS_CTRL_LAMP_TEST];
        st_d.lamps.unsafe = lamp_test | steady_next
            | (warn & st_d.blink_ph);
        st_d.lamps.online = lamp_test | st_d.online;
        st_d.lamps.wprot = lamp_test | st_q.sw_stab.wprot;
        st_d.lamps.act_a = lamp_test | (st_q.se_s2.act_a & st_d.drive.port_a_en);
        st_d.lamps.act_b = lamp_test | (st_q.se_s2.act_b & st_d.drive.port_b_en);

        // Events that set sticky status bits.
        ev[`DPS_EV_ONLINE] = st_d.online & ~st_q.online;
        ev[`DPS_EV_DONE] = op_done_i;
        ev[`DPS_EV_ERR] = err_det_i;
        ev[`DPS_EV_UNSAFE] = steady_next & ~steady_now;

        // Panel snapshot for software.
        panel = {st_d.spin,
                 st_q.sw_stab.wprot,
                 st_d.drive.port_b_en,
                 st_d.drive.port_a_en,
                 st_d.online};

        // Wishbone classic slave answering one cycle after the strobe.
        take = wb_cyc_i & wb_stb_i & ~st_q.ack;
        st_d.ack = take;
        st_d.dat = '0;
        if (take)
        begin
            if (wb_we_i)
            begin
                if (wb_sel_i[0])
                begin
                    case (wb_adr_i)
                        `DPS_OFF_MASK:
                        begin
                            st_d.mask = wb_dat_i[`DPS_EV_W-1:0];
                        end
                        `DPS_OFF_CTRL:
                        begin
                            st_d.ctrl = wb_dat_i[`DPS_CTRL_W-1:0];
                        end
                        // Read-only registers ignore writes.
                        `DPS_OFF_STATUS,
                        `DPS_OFF_PANEL:
                        begin
                            st_d.ctrl = st_q.ctrl;
                        end
                        default:
                        begin
                            st_d.mask = st_q.mask;
                        end
                    endcase
                end
            end
            else
            begin
                case (wb_adr_i)
                    `DPS_OFF_STATUS:
                    begin
                        st_d.dat[`DPS_EV_W-1:0] = st_q.status;
                        clr = st_q.status;
                    end
                    `DPS_OFF_MASK:
                    begin
                        st_d.dat[`DPS_EV_W-1:0] = st_q.mask;
                    end
                    `DPS_OFF_CTRL:
                    begin
                        st_d.dat[`DPS_CTRL_W-1:0] = st_q.ctrl;
                    end
                    `DPS_OFF_PANEL:
                    begin
                        st_d.dat[`DPS_PANEL_W-1:0] = panel;
                    end
                    default:
                    begin
                        st_d.dat = '0;
                    end
                endcase
            end
        end

        // A new event wins over the clear by a status read.
        st_d.status = (st_q.status & ~clr) | ev;
        st_d.irq = |(st_d.status & st_d.mask);
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st_q.sw_s1 <= '0;
            st_q.sw_s2 <= '0;
            st_q.sw_s3 <= '0;
            st_q.sw_stab <= '0;
            st_q.db_cnt <= '0;
            st_q.se_s1 <= '0;
            st_q.se_s2 <= '0;
            st_q.spin <= SP_STOP;
            st_q.spin_cnt <= '0;
            st_q.blink_cnt <= '0;
            st_q.blink_ph <= 1'b1;
            st_q.online <= 1'b0;
            st_q.status <= '0;
            st_q.mask <= `DPS_MASK_RST;
            st_q.ctrl <= `DPS_CTRL_RST;
            st_q.ack <= 1'b0;
            st_q.dat <= '0;
            st_q.irq <= 1'b0;
            st_q.lamps.unsafe <= 1'b0;
            st_q.lamps.online <= 1'b0;
            st_q.lamps.wprot <= 1'b0;
            st_q.lamps.act_a <= 1'b0;
            st_q.lamps.act_b <= 1'b0;
            st_q.drive.motor_on <= 1'b0;
            st_q.drive.port_a_en <= 1'b0;
            st_q.drive.port_b_en <= 1'b0;
            st_q.drive.write_ok <= 1'b0;
        end
        else if (ce)
        begin
            st_q <= st_d;
        end
    end

    // Every output comes straight from the state register.
    assign wb_dat_o = st_q.dat;
    assign wb_ack_o = st_q.ack;
    assign irq_o = st_q.irq;
    assign lamp_o = st_q.lamps;
    assign drive_o = st_q.drive;

endmodule : dps_panel
`default_nettype wire

// [bench/dps_panel_sva.sv]
// Checker on the ports of the panel status block.
`timescale 1ns/1ps
`default_nettype none
module dps_panel_sva
    import dps_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire dps_sw_t sw_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire dps_lamp_t lamp_o,
    input wire dps_drive_t drive_o
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_stop;
        (ce && !sw_i.spin_start) [*8] |-> ##2 !drive_o.motor_on;
    endproperty
    a_stop: assert property (p_stop) else $error("motor still on");
    property p_avail;
        (ce && !sw_i.avail) [*8] |-> ##2 !(drive_o.port_a_en || drive_o.port_b_en);
    endproperty
    a_avail: assert property (p_avail) else $error("port on while away");
    property p_wprot;
        (ce && sw_i.wprot) [*8] |-> ##2 !drive_o.write_ok;
    endproperty
    a_wprot: assert property (p_wprot) else $error("write allowed");
    property p_only_a;
        (ce && sw_i.sel_a && !sw_i.sel_b) [*8] |-> ##2 !drive_o.port_b_en;
    endproperty
    a_only_a: assert property (p_only_a) else $error("port b on");
    property p_only_b;
        (ce && sw_i.sel_b && !sw_i.sel_a) [*8] |-> ##2 !drive_o.port_a_en;
    endproperty
    a_only_b: assert property (p_only_b) else $error("port a on");
    property p_act;
        lamp_o.act_a && !lamp_o.wprot |-> drive_o.port_a_en || $past(drive_o.port_a_en);
    endproperty
    a_act: assert property (p_act) else $error("lamp a without port");
    property p_settle;
        $rose(drive_o.port_a_en) |-> $past(sw_i.avail, 4);
    endproperty
    a_settle: assert property (p_settle) else $error("switch used early");
    property p_ack;
        ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bad bus answer");
endmodule : dps_panel_sva
bind dps_panel dps_panel_sva u_sva (.clock(clock), .rst(rst), .ce(ce), .sw_i(sw_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .lamp_o(lamp_o),
    .drive_o(drive_o));
`default_nettype wire

// [bench/dps_host_pair.sv]
// Two host adapters that access the drive on enabled ports.
`timescale 1ns/1ps
`default_nettype none
module dps_host_pair
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [1:0] en,
    input wire logic [1:0] want,
    output logic [1:0] act
);
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            act <= 2'b00;
        else
            act <= want & en;
    end
endmodule : dps_host_pair
`default_nettype wire

// [bench/dps_panel_tb.sv]
// Self-checking bench for the panel status block.
`timescale 1ns/1ps
`default_nettype none
module dps_panel_tb;
    import dps_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic spd = 1'b0;
    logic [1:0] warn = 2'h0;
    logic done = 1'b0;
    logic err = 1'b0;
    logic [1:0] want = 2'h0;
    logic [1:0] act;
    logic irq;
    logic ack;
    logic [31:0] rdat;
    logic [31:0] rd;
    dps_sw_t sw = '0;
    dps_lamp_t lamp;
    dps_drive_t drv;
    int num_errors = 0;
    int n_compared = 0;
    wire dps_sense_t sense = {spd, warn, act};
    always #2 clock = ~clock;
    dps_panel #(.DEBOUNCE_CYC(4), .BLINK_CYC(8), .SPINUP_CYC(50)) dut (.clock(clock),
        .rst(rst), .ce(1'b1), .sw_i(sw), .sense_i(sense), .op_done_i(done), .err_det_i(err),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .lamp_o(lamp),
        .drive_o(drv));
    dps_host_pair host (.clock(clock), .rst(rst), .en({drv.port_a_en, drv.port_b_en}),
        .want(want), .act(act));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask : tick
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
            @(posedge clock);
        while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
    endtask : bus
    task automatic lit(input int n, input int exp);
        int c;
        c = 0;
        repeat (n)
        begin
            @(negedge clock);
            if (lamp.unsafe === 1'b1)
                c++;
        end
        chk(c, exp);
    endtask : lit
    task automatic t_regs;
        bus(1'b0, 4'h4, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 4'h4, 32'hffff_ffff);
        bus(1'b0, 4'h4, 32'h0);
        chk(rd, 32'hf);
        bus(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h0);
    endtask : t_regs
    task automatic t_online;
        @(posedge clock);
        sw <= 5'b11000;
        tick(12);
        chk(drv, 4'b1001);
        @(posedge clock);
        spd <= 1'b1;
        tick(6);
        chk(drv, 4'b1111);
        chk(lamp, 5'b01000);
        chk(irq, 1'b1);
        bus(1'b0, 4'hc, 32'h0);
        chk(rd, 32'h47);
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h1);
        tick(1);
        chk(irq, 1'b0);
        @(posedge clock);
        sw.avail <= 1'b0;
        tick(1);
        @(posedge clock);
        sw.avail <= 1'b1;
        tick(10);
        chk(drv, 4'b1111);
    endtask : t_online
    task automatic t_sel;
        @(posedge clock);
        {sw.sel_a, sw.sel_b} <= 2'b10;
        tick(10);
        chk(drv, 4'b1101);
        @(posedge clock);
        {sw.sel_a, sw.sel_b} <= 2'b01;
        tick(10);
        chk(drv, 4'b1011);
        @(posedge clock);
        {sw.sel_a, sw.sel_b} <= 2'b00;
    endtask : t_sel
    task automatic t_wprot;
        @(posedge clock);
        sw.wprot <= 1'b1;
        want <= 2'b01;
        tick(10);
        chk(drv, 4'b1110);
        chk(lamp, 5'b01101);
        @(posedge clock);
        sw.wprot <= 1'b0;
        want <= 2'b10;
        tick(10);
        chk(lamp, 5'b01010);
    endtask : t_wprot
    task automatic t_events;
        bus(1'b1, 4'h4, 32'hb);
        err <= 1'b1;
        @(posedge clock);
        err <= 1'b0;
        tick(1);
        chk(irq, 1'b0);
        @(posedge clock);
        done <= 1'b1;
        @(posedge clock);
        done <= 1'b0;
        tick(1);
        chk(irq, 1'b1);
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h6);
        bus(1'b1, 4'h4, 32'hf);
    endtask : t_events
    task automatic t_unsafe;
        @(posedge clock);
        want <= 2'b00;
        warn <= 2'b10;
        tick(4);
        lit(32, 16);
        @(posedge clock);
        warn <= 2'b01;
        tick(4);
        lit(32, 16);
        @(posedge clock);
        warn <= 2'b00;
        spd <= 1'b0;
        tick(6);
        lit(20, 20);
        chk(lamp, 5'b10000);
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h8);
        @(posedge clock);
        sw.spin_start <= 1'b0;
        tick(10);
        chk(drv, 4'b0001);
        chk(lamp, 5'b00000);
    endtask : t_unsafe
    task automatic t_lamp;
        bus(1'b1, 4'h8, 32'h1);
        bus(1'b0, 4'h8, 32'h0);
        chk(rd, 32'h1);
        tick(1);
        chk(lamp, 5'b11111);
        @(posedge clock);
        rst <= 1'b1;
        tick(2);
        chk(drv, 4'h0);
        chk(lamp, 5'h00);
        chk(irq, 1'b0);
        @(posedge clock);
        rst <= 1'b0;
        tick(2);
        chk(drv, 4'b0001);
        chk(lamp, 5'h00);
        bus(1'b0, 4'h8, 32'h0);
        chk(rd, 32'h0);
    endtask : t_lamp
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_online();
        t_sel();
        t_wprot();
        t_events();
        t_unsafe();
        t_lamp();
        close_out();
    end
    initial
    begin
        #20000;
        num_errors++;
        close_out();
    end
endmodule : dps_panel_tb
`default_nettype wire
